// ===== verilog/aso_pkg.sv
// Purpose: Shared constants and types of the sample output block.
// Assumes: 20 MHz register clock, 12-bit samples.
// Notes:   Register offsets are byte addresses on a 4-bit address.
package aso_pkg;
  // ==========================================================
  // Widths
  localparam int AW  = 4;
  localparam int DW  = 32;
  localparam int SW  = 12;
  localparam int WW  = SW + 1;
  localparam int PAW = 4;
  // ==========================================================
  // Register map
  localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
  localparam logic [AW-1:0] ADDR_STAT = 4'h4;
  localparam logic [AW-1:0] ADDR_LAT  = 4'h8;
  localparam int CTL_MODE = 0;
  localparam int CTL_FMT  = 2;
  localparam int CTL_OEN  = 4;
  localparam int CTL_PD   = 5;
  localparam int CTL_W    = 6;
  localparam logic [CTL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [PAW-1:0]   LAT_RST  = 4'h3;
  // ==========================================================
  // Codes
  localparam logic [SW-1:0] CODE_MAX = 12'hfff;
  localparam logic [SW-1:0] CODE_MIN = 12'h000;
  localparam int MSB = SW - 1;
  localparam logic [6:0] SETTLE_CYC = 7'h64;
  // ==========================================================
  // Timing
  localparam int MCLK_PERIOD_NS = 50;
  localparam int STOP_TIME_NS   = 10000;
  localparam int STOP_CYC       = STOP_TIME_NS / MCLK_PERIOD_NS;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    LVL_GND      = 2'h0,
    LVL_THIRD    = 2'h1,
    LVL_TWOTHIRD = 2'h2,
    LVL_VDD      = 2'h3
  } aso_lvl_t;
  typedef enum logic [3:0] {
    OM_FULL  = 4'h1,
    OM_SIMUL = 4'h2,
    OM_INTER = 4'h4,
    OM_LVDS  = 4'h8
  } aso_omode_t;
endpackage : aso_pkg

// ===== verilog/aso_sync.sv
// Purpose: Two-flop synchroniser for levels and static words.
// Assumes: Each bit is a slow level or a quasi-static setting.
// Notes:   Only q may be read; the first stage feeds nothing else.
`timescale 1ns/1ns
module aso_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : aso_sync

// ===== verilog/aso_delay_mem.sv
// Purpose: Circular store for the conversion pipeline delay.
// Assumes: One write and one read per encode cycle.
// Notes:   Read data come from a register; storage has no reset.
`timescale 1ns/1ns
module aso_delay_mem
  import aso_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  input  wire logic [PAW-1:0] wr_addr_i,
  input  wire logic [WW-1:0]  wr_data_i,
  input  wire logic [PAW-1:0] rd_addr_i,
  output logic      [WW-1:0]  rd_data_o
);
  logic [WW-1:0] mem [2**PAW];

  always_ff @(posedge clk_i)
  begin
    mem[wr_addr_i] <= wr_data_i;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rd_data_o <= '0;
    else
      rd_data_o <= mem[rd_addr_i];
  end
endmodule : aso_delay_mem

// ===== verilog/aso_top.sv
// Purpose: Output formatting and bus steering of a 12-bit converter.
// Assumes: Core word arrives on the encode clock; register port on mclk_i.
// Notes:   Encode clock is the link domain; settings cross as static words.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ns
module aso_top
  import aso_pkg::*;
#(
  parameter int STOP_LIMIT = STOP_CYC
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [DW-1:0] rdata_o,
  input  wire logic          encode_clock_pos_i,
  input  wire logic [SW-1:0] core_code_i,
  input  wire logic          core_over_i,
  input  wire logic          core_under_i,
  output logic      [SW-1:0] sample_bits_a_o,
  output logic               range_error_bus_a_o,
  output logic               forwarded_clock_bus_a_o,
  output logic               bus_a_oe_o,
  output logic      [SW-1:0] sample_bits_b_o,
  output logic               range_error_bus_b_o,
  output logic               forwarded_clock_bus_b_o,
  output logic               bus_b_oe_o,
  output logic      [SW-1:0] sample_bits_p_o,
  output logic      [SW-1:0] sample_bits_n_o,
  output logic               range_error_flag_p_o,
  output logic               range_error_flag_n_o,
  output logic               forwarded_clock_p_o,
  output logic               forwarded_clock_n_o,
  output logic               lvds_oe_o
);
  // ==========================================================
  // Register port and power state (mclk domain)
  logic [CTL_W-1:0] ctrl_q;
  logic [PAW-1:0]   lat_q;
  logic             sleep;
  logic             nap;
  logic             outs_on;
  logic             stopped_q;
  logic             settle_s;
  logic [15:0]      stop_cnt_q;
  logic             tog_s;
  logic             tog_d_q;
  logic [1:0]       mode_lvl;

  assign mode_lvl = ctrl_q[CTL_MODE +: 2];
  assign sleep    = ctrl_q[CTL_PD] & ctrl_q[CTL_OEN];
  assign nap      = ctrl_q[CTL_PD] & ~ctrl_q[CTL_OEN];
  assign outs_on  = ~ctrl_q[CTL_PD] & ~ctrl_q[CTL_OEN];

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= CTRL_RST;
      lat_q  <= LAT_RST;
    end
    else if (wr_i && addr_i == ADDR_CTRL)
      ctrl_q <= wdata_i[CTL_W-1:0];
    else if (wr_i && addr_i == ADDR_LAT)
      lat_q  <= wdata_i[PAW-1:0];
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= '0;
    else if (rd_i && addr_i == ADDR_CTRL)
      rdata_o <= {{(DW-CTL_W){1'b0}}, ctrl_q};
    else if (rd_i && addr_i == ADDR_STAT)
      rdata_o <= {28'h0000000, settle_s, stopped_q, nap, sleep};
    else if (rd_i && addr_i == ADDR_LAT)
      rdata_o <= {{(DW-PAW){1'b0}}, lat_q};
    else
      rdata_o <= '0;
  end

  // Enables are registered so the pads never see a decode glitch.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus_a_oe_o <= 1'b0;
      bus_b_oe_o <= 1'b0;
      lvds_oe_o  <= 1'b0;
    end
    else
    begin
      bus_a_oe_o <= outs_on && mode_lvl != LVL_VDD;
      bus_b_oe_o <= outs_on && (mode_lvl == LVL_THIRD || mode_lvl == LVL_TWOTHIRD);
      lvds_oe_o  <= outs_on && mode_lvl == LVL_VDD;
    end
  end

  // A stopped encode clock cannot be seen from its own domain, so a
  // watchdog on mclk_i watches a toggle that the encode domain flips.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tog_d_q    <= 1'b0;
      stop_cnt_q <= '0;
      stopped_q  <= 1'b0;
    end
    else
    begin
      tog_d_q <= tog_s;
      if (tog_s != tog_d_q)
      begin
        stop_cnt_q <= '0;
        stopped_q  <= 1'b0;
      end
      else if (stop_cnt_q == 16'(STOP_LIMIT))
        stopped_q  <= 1'b1;
      else
        stop_cnt_q <= stop_cnt_q + 16'h0001;
    end
  end

  // ==========================================================
  // Encode domain
  logic [1:0]       rst_e_q;
  logic             rst_e;
  logic [9:0]       cfg_e;
  logic [PAW-1:0]   lat_e;
  logic [1:0]       fmt_e;
  logic [1:0]       mode_e;
  logic             nap_e;
  logic             stop_e;
  logic             twos_e;
  logic             stab_e;
  aso_omode_t       omode_e;
  logic [SW-1:0]    ob_code;
  logic [SW-1:0]    fmt_code_q;
  logic             fmt_flag_q;
  logic [PAW-1:0]   wptr_q;
  logic [WW-1:0]    pipe_w;
  logic [WW-1:0]    hold_q;
  logic [WW-1:0]    bus_a_q;
  logic [WW-1:0]    bus_b_q;
  logic             ph_q;
  logic             enc_tog_q;
  logic             nap_d_q;
  logic             stop_d_q;
  logic [6:0]       settle_q;

  always_ff @(posedge encode_clock_pos_i or posedge rst_i)
  begin
    if (rst_i)
      rst_e_q <= 2'b11;
    else
      rst_e_q <= {rst_e_q[0], 1'b0};
  end
  assign rst_e = rst_e_q[1];

  // Settings change only while the link is idle, so bitwise sync is safe.
  aso_sync #(
    .W (10)
  ) u_cfg_sync (
    .clk_i (encode_clock_pos_i),
    .rst_i (rst_i),
    .d_i   ({lat_q, ctrl_q[CTL_FMT +: 2], mode_lvl, nap, stopped_q}),
    .q_o   (cfg_e)
  );
  assign {lat_e, fmt_e, mode_e, nap_e, stop_e} = cfg_e;

  aso_sync #(
    .W (2)
  ) u_back_sync (
    .clk_i (mclk_i),
    .rst_i (rst_i),
    .d_i   ({enc_tog_q, settle_q != 7'h00}),
    .q_o   ({tog_s, settle_s})
  );

  assign twos_e = fmt_e[1];
  assign stab_e = fmt_e == LVL_THIRD || fmt_e == LVL_TWOTHIRD;

  always_comb
  begin
    unique case (mode_e)
      LVL_GND:      omode_e = OM_FULL;
      LVL_THIRD:    omode_e = OM_SIMUL;
      LVL_TWOTHIRD: omode_e = OM_INTER;
      default:      omode_e = OM_LVDS;
    endcase
  end

  always_comb
  begin
    if (core_over_i)
      ob_code = CODE_MAX;
    else if (core_under_i)
      ob_code = CODE_MIN;
    else
      ob_code = core_code_i;
  end

  always_ff @(posedge encode_clock_pos_i or posedge rst_e)
  begin
    if (rst_e)
    begin
      fmt_code_q <= CODE_MIN;
      fmt_flag_q <= 1'b0;
    end
    else
    begin
      fmt_code_q <= {ob_code[MSB] ^ twos_e, ob_code[MSB-1:0]};
      fmt_flag_q <= core_over_i | core_under_i;
    end
  end

  // Only rising encode edges clock this logic, whether the stabilizer is on or off; the external
  // falling edge still reaches forwarded_clock_bus_a_o in full rate and the LVDS clock pair.
  always_ff @(posedge encode_clock_pos_i or posedge rst_e)
  begin
    if (rst_e)
    begin
      wptr_q    <= '0;
      enc_tog_q <= 1'b0;
    end
    else
    begin
      wptr_q    <= wptr_q + 4'h1;
      enc_tog_q <= ~enc_tog_q;
    end
  end

  aso_delay_mem u_delay (
    .clk_i     (encode_clock_pos_i),
    .rst_i     (rst_e),
    .wr_addr_i (wptr_q),
    .wr_data_i ({fmt_flag_q, fmt_code_q}),
    .rd_addr_i (wptr_q - lat_e),
    .rd_data_o (pipe_w)
  );

  // Phase of the half-rate forwarded clocks; clock B is its inverse.
  always_ff @(posedge encode_clock_pos_i or posedge rst_e)
  begin
    if (rst_e)
      ph_q <= 1'b0;
    else if (omode_e == OM_SIMUL || omode_e == OM_INTER)
      ph_q <= ~ph_q;
    else
      ph_q <= 1'b0;
  end

  always_ff @(posedge encode_clock_pos_i or posedge rst_e)
  begin
    if (rst_e)
    begin
      bus_a_q <= '0;
      bus_b_q <= '0;
      hold_q  <= '0;
    end
    else
    begin
      unique case (omode_e)
        OM_FULL, OM_LVDS:
          bus_a_q <= pipe_w;
        OM_INTER:
        begin
          if (!ph_q)
            bus_a_q <= pipe_w;
          else
            bus_b_q <= pipe_w;
        end
        OM_SIMUL:
        begin
          if (ph_q)
            hold_q  <= pipe_w;
          else
          begin
            bus_a_q <= hold_q;
            bus_b_q <= pipe_w;
          end
        end
        default:
          bus_a_q <= pipe_w;
      endcase
    end
  end

  // Recovery counter: the device keeps converting, software reads the flag.
  always_ff @(posedge encode_clock_pos_i or posedge rst_e)
  begin
    if (rst_e)
    begin
      nap_d_q  <= 1'b0;
      stop_d_q <= 1'b0;
      settle_q <= '0;
    end
    else
    begin
      nap_d_q  <= nap_e;
      stop_d_q <= stop_e;
      if (nap_d_q && !nap_e)
        settle_q <= SETTLE_CYC;
      else if (stop_d_q && !stop_e && stab_e)
        settle_q <= SETTLE_CYC;
      else if (settle_q != 7'h00)
        settle_q <= settle_q - 7'h01;
    end
  end

  // ==========================================================
  // Pins
  assign sample_bits_a_o         = bus_a_q[SW-1:0];
  assign range_error_bus_a_o     = bus_a_q[SW];
  assign sample_bits_b_o         = bus_b_q[SW-1:0];
  assign range_error_bus_b_o     = bus_b_q[SW];
  assign sample_bits_p_o         = bus_a_q[SW-1:0];
  assign sample_bits_n_o         = ~bus_a_q[SW-1:0];
  assign range_error_flag_p_o    = bus_a_q[SW];
  assign range_error_flag_n_o    = ~bus_a_q[SW];
  // Gated clock copies; held low while the pins are released.
  assign forwarded_clock_bus_a_o = bus_a_oe_o &
                                   (omode_e == OM_FULL ? encode_clock_pos_i : ph_q);
  assign forwarded_clock_bus_b_o = bus_b_oe_o & ~ph_q;
  assign forwarded_clock_p_o     = lvds_oe_o & encode_clock_pos_i;
  assign forwarded_clock_n_o     = lvds_oe_o & ~encode_clock_pos_i;

  // ==========================================================
  // Assertions
  property p_clamp_hi;
    @(posedge encode_clock_pos_i) disable iff (rst_e)
    core_over_i && !twos_e |=> fmt_code_q == CODE_MAX && fmt_flag_q;
  endproperty
  a_clamp_hi: assert property (p_clamp_hi) else $error("over range not clamped");

  property p_clamp_lo;
    @(posedge encode_clock_pos_i) disable iff (rst_e)
    core_under_i && !core_over_i && !twos_e |=> fmt_code_q == CODE_MIN && fmt_flag_q;
  endproperty
  a_clamp_lo: assert property (p_clamp_lo) else $error("under range not clamped");

  property p_twos;
    @(posedge encode_clock_pos_i) disable iff (rst_e)
    twos_e && !core_over_i && !core_under_i |=>
      fmt_code_q == {~$past(core_code_i[MSB]), $past(core_code_i[MSB-1:0])} && !fmt_flag_q;
  endproperty
  a_twos: assert property (p_twos) else $error("two's complement code wrong");

  property p_full;
    @(posedge encode_clock_pos_i) disable iff (rst_e)
    omode_e == OM_FULL |=> bus_a_q == $past(pipe_w);
  endproperty
  a_full: assert property (p_full) else $error("full rate bus A missed a sample");

  property p_inter_b;
    @(posedge encode_clock_pos_i) disable iff (rst_e)
    omode_e == OM_INTER && ph_q |=> bus_b_q == $past(pipe_w) && !ph_q ##1 $stable(bus_b_q);
  endproperty
  a_inter_b: assert property (p_inter_b) else $error("interleaved bus B timing");

  property p_simul;
    @(posedge encode_clock_pos_i) disable iff (rst_e)
    omode_e == OM_SIMUL && !ph_q |=> bus_b_q == $past(pipe_w) && bus_a_q == $past(hold_q);
  endproperty
  a_simul: assert property (p_simul) else $error("simultaneous buses not paired");

  property p_settle;
    @(posedge encode_clock_pos_i) disable iff (rst_e)
    nap_d_q && !nap_e |=> settle_q == SETTLE_CYC ##99 settle_q == 7'h01;
  endproperty
  a_settle: assert property (p_settle) else $error("nap recovery count wrong");

  property p_off;
    @(posedge mclk_i) disable iff (rst_i)
    ctrl_q[CTL_OEN] || ctrl_q[CTL_PD] |=> !bus_a_oe_o && !bus_b_oe_o && !lvds_oe_o;
  endproperty
  a_off: assert property (p_off) else $error("outputs driven while disabled");

  property p_lvds;
    @(posedge mclk_i) disable iff (rst_i)
    outs_on && mode_lvl == LVL_VDD |=> lvds_oe_o && !bus_a_oe_o && !bus_b_oe_o;
  endproperty
  a_lvds: assert property (p_lvds) else $error("LVDS mode enables wrong pins");

  c_inter: cover property (@(posedge encode_clock_pos_i) omode_e == OM_INTER ##2 ph_q);
  c_simul: cover property (@(posedge encode_clock_pos_i) omode_e == OM_SIMUL ##2 ph_q);
  c_over:  cover property (@(posedge encode_clock_pos_i) core_over_i ##1 fmt_flag_q);
  c_stop:  cover property (@(posedge mclk_i) $fell(stopped_q));
endmodule : aso_top

// ===== testbench/aso_capture_model.sv
// Purpose: Capture logic that latches converter words from the output buses.
// Assumes: Pins are looked at only while their output enable is high.
// Notes:   Counts bus B words that are not the successor of their bus A word.
`timescale 1ns/1ns
module aso_capture_model
  import aso_pkg::*;
(
  input  wire logic          simul_i,
  input  wire logic [SW-1:0] a_i,
  input  wire logic          fa_i,
  input  wire logic          ca_i,
  input  wire logic          oea_i,
  input  wire logic [SW-1:0] b_i,
  input  wire logic          fb_i,
  input  wire logic          cb_i,
  input  wire logic          oeb_i,
  input  wire logic [SW-1:0] p_i,
  input  wire logic [SW-1:0] n_i,
  input  wire logic          fp_i,
  input  wire logic          cp_i,
  input  wire logic          oel_i,
  output logic      [SW-1:0] cap_a_o,
  output logic               cap_fa_o,
  output logic      [SW-1:0] cap_b_o,
  output logic               cap_fb_o,
  output logic      [SW-1:0] cap_p_o,
  output logic      [SW-1:0] cap_n_o,
  output logic               cap_fp_o,
  output logic      [15:0]   pairs_o,
  output logic      [15:0]   pair_err_o
);
  // ==========================================================
  // Capture
  initial
  begin
    pairs_o    = 16'h0000;
    pair_err_o = 16'h0000;
  end
  // Bus A changes at the rise, so the fall is the safe moment.
  always @(negedge ca_i)
    if (oea_i)
      {cap_a_o, cap_fa_o} <= {a_i, fa_i};
  // Simultaneous bus B is taken at the rise, interleaved at the fall.
  always @(cb_i)
    if (oeb_i && (cb_i == simul_i))
    begin
      {cap_b_o, cap_fb_o} <= {b_i, fb_i};
      pairs_o <= pairs_o + 16'h0001;
      if (b_i !== (simul_i ? a_i : cap_a_o) + 12'h001)
        pair_err_o <= pair_err_o + 16'h0001;
    end
  // LVDS words are taken on the falling edge of the positive clock leg.
  always @(negedge cp_i)
    if (oel_i)
      {cap_p_o, cap_n_o, cap_fp_o} <= {p_i, n_i, fp_i};
endmodule : aso_capture_model

// ===== testbench/aso_top_tb.sv
// Purpose: Self-checking bench of the sample output block.
// Assumes: Register clock 50 ns, encode clock 80 ns, small stop limit.
// Notes:   Reset reads and format rows run first; latency, enables and recovery follow.
`timescale 1ns/1ns
module aso_top_tb;
  import aso_pkg::*;
  typedef struct packed {
    logic [1:0]    fmt;
    logic [SW-1:0] code;
    logic          ov;
    logic          un;
    logic [SW-1:0] exp;
    logic          fl;
  } aso_row_t;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [AW-1:0] addr_i = 4'h0;
  logic [DW-1:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic encode = 1'b0;
  logic enc_run = 1'b1;
  logic [SW-1:0] core_code = 12'h000;
  logic core_over = 1'b0;
  logic core_under = 1'b0;
  logic [SW-1:0] cmd_code = 12'h000;
  logic cmd_over = 1'b0;
  logic cmd_under = 1'b0;
  logic ramp = 1'b0;
  logic simul = 1'b0;
  logic [DW-1:0] rdata_o, d;
  logic [SW-1:0] sa, sb, sp, sn, cap_a, cap_b, cap_p, cap_n;
  logic fa, fb, ca, cb, oea, oeb, fp, fn, cp, cn, oel, cap_fa, cap_fb, cap_fp;
  logic [15:0] pairs, pair_err, e0, p0;
  logic [2:0] seen;
  int n_errors = 0;
  int samples_checked = 0;
  int n;
  int lat;
  aso_row_t rows [9] = '{
    '{2'h0, 12'h800, 1'b0, 1'b0, 12'h800, 1'b0},
    '{2'h3, 12'h800, 1'b0, 1'b0, 12'h000, 1'b0},
    '{2'h1, 12'hfff, 1'b0, 1'b0, 12'hfff, 1'b0},
    '{2'h2, 12'hfff, 1'b0, 1'b0, 12'h7ff, 1'b0},
    '{2'h0, 12'h5a5, 1'b1, 1'b0, 12'hfff, 1'b1},
    '{2'h2, 12'h5a5, 1'b1, 1'b0, 12'h7ff, 1'b1},
    '{2'h1, 12'h5a5, 1'b0, 1'b1, 12'h000, 1'b1},
    '{2'h3, 12'h5a5, 1'b0, 1'b1, 12'h800, 1'b1},
    '{2'h2, 12'h7ff, 1'b0, 1'b0, 12'hfff, 1'b0}};
  // ==========================================================
  // Clocks and converter core stand-in
  initial
  begin
    forever #25 mclk_i = ~mclk_i;
  end
  // An 80 ns period with even halves sits inside the allowed rate range.
  initial
  begin
    #17;
    forever
    begin
      #40;
      if (enc_run)
        encode = ~encode;
    end
  end
  always @(posedge encode)
  begin
    core_code  <= ramp ? core_code + 12'h001 : cmd_code;
    core_over  <= cmd_over;
    core_under <= cmd_under;
  end
  aso_top #(.STOP_LIMIT(20)) u_aso_top (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .encode_clock_pos_i(encode), .core_code_i(core_code), .core_over_i(core_over),
    .core_under_i(core_under), .sample_bits_a_o(sa), .range_error_bus_a_o(fa),
    .forwarded_clock_bus_a_o(ca), .bus_a_oe_o(oea), .sample_bits_b_o(sb),
    .range_error_bus_b_o(fb), .forwarded_clock_bus_b_o(cb), .bus_b_oe_o(oeb),
    .sample_bits_p_o(sp), .sample_bits_n_o(sn), .range_error_flag_p_o(fp),
    .range_error_flag_n_o(fn), .forwarded_clock_p_o(cp), .forwarded_clock_n_o(cn),
    .lvds_oe_o(oel));
  aso_capture_model u_aso_capture_model (.simul_i(simul), .a_i(sa), .fa_i(fa), .ca_i(ca),
    .oea_i(oea), .b_i(sb), .fb_i(fb), .cb_i(cb), .oeb_i(oeb), .p_i(sp), .n_i(sn),
    .fp_i(fp), .cp_i(cp), .oel_i(oel), .cap_a_o(cap_a), .cap_fa_o(cap_fa),
    .cap_b_o(cap_b), .cap_fb_o(cap_fb), .cap_p_o(cap_p), .cap_n_o(cap_n),
    .cap_fp_o(cap_fp), .pairs_o(pairs), .pair_err_o(pair_err));
  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] seen_v, input logic [31:0] exp);
    samples_checked++;
    if (seen_v !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen_v);
    end
  endtask : chk
  task automatic reg_wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask : reg_wr
  task automatic rd(input logic [AW-1:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task automatic settle(input int k);
    repeat (k) @(posedge encode);
  endtask : settle
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // ==========================================================
  // Watchdog, sized well above the expected run of some 120 us
  initial
  begin
    #600000;
    n_errors++;
    complete_run();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(ADDR_CTRL);
    chk("ctrl reset", d, 32'(CTRL_RST));
    rd(ADDR_LAT);
    chk("lat reset", d, 32'(LAT_RST));
    rd(4'hc);
    chk("unmapped read", d, 32'h0);
    foreach (rows[i])
    begin
      reg_wr(ADDR_CTRL, 32'(rows[i].fmt) << CTL_FMT);
      {cmd_code, cmd_over, cmd_under} = {rows[i].code, rows[i].ov, rows[i].un};
      settle(30);
      chk("bus a word", cap_a, rows[i].exp);
      chk("bus a flag", cap_fa, rows[i].fl);
    end
    // LVDS carries the same word as a pair with its inverse.
    reg_wr(ADDR_CTRL, 32'h3 | (32'h2 << CTL_FMT));
    {cmd_code, cmd_over, cmd_under} = {12'h5a5, 1'b0, 1'b1};
    settle(30);
    chk("lvds word", {cap_p, cap_n, cap_fp}, {12'h800, 12'h7ff, 1'b1});
    #1 chk("lvds n legs", {fn, cn}, 2'b00);
    {cmd_code, cmd_over, cmd_under} = {12'h123, 1'b0, 1'b0};
    for (int m = 1; m < 3; m++)
    begin
      simul = (m == 1);
      ramp  = 1'b1;
      reg_wr(ADDR_CTRL, 32'(m));
      settle(20);
      e0 = pair_err;
      p0 = pairs;
      settle(40);
      chk("pair order", pair_err - e0, 16'h0000);
      chk("pair count", pairs - p0, 16'h0014);
      chk("bus b flag", cap_fb, 1'b0);
    end
    ramp = 1'b0;
    reg_wr(ADDR_CTRL, 32'h0);
    // The store wraps at zero, which makes the longest delay.
    foreach (rows[i])
    begin
      if (i > 2)
        break;
      lat = (i == 0) ? 3 : (i == 1) ? 5 : 0;
      reg_wr(ADDR_LAT, 32'(lat));
      cmd_code = 12'h123;
      settle(40);
      #1 cmd_code = 12'h456;
      n = 0;
      while (sa !== 12'h456 && n < 40)
      begin
        @(posedge encode);
        #1 n++;
      end
      chk("latency", 32'(n), 32'((lat == 0 ? 16 : lat) + 4));
      chk("clock a high", ca, 1'b1);
    end
    for (int m = 0; m < 4; m++)
    begin
      reg_wr(ADDR_CTRL, 32'(m));
      settle(10);
      chk("enables", {oea, oeb, oel}, m == 0 ? 3'b100 : m == 3 ? 3'b001 : 3'b110);
      reg_wr(ADDR_CTRL, 32'(m) | (32'h1 << CTL_OEN));
      settle(10);
      seen = 3'b000;
      repeat (8)
      begin
        @(posedge encode);
        #1 seen = seen | {ca, cb, cp};
      end
      chk("disabled", {oea, oeb, oel, seen}, 6'h00);
    end
    reg_wr(ADDR_CTRL, (32'h1 << CTL_PD) | (32'h1 << CTL_OEN));
    settle(10);
    rd(ADDR_STAT);
    chk("sleep", {d[1:0], oea, oeb, oel}, 5'h08);
    reg_wr(ADDR_CTRL, 32'h1 << CTL_PD);
    settle(10);
    rd(ADDR_STAT);
    chk("nap", {d[1:0], oea, oeb, oel}, 5'h10);
    reg_wr(ADDR_CTRL, 32'h0);
    settle(5);
    rd(ADDR_STAT);
    chk("nap recovery", d[3], 1'b1);
    settle(110);
    rd(ADDR_STAT);
    chk("nap recovered", d[3], 1'b0);
    for (int f = 0; f < 4; f++)
    begin
      reg_wr(ADDR_CTRL, 32'(f) << CTL_FMT);
      settle(10);
      enc_run = 1'b0;
      repeat (40) @(posedge mclk_i);
      rd(ADDR_STAT);
      chk("clock stopped", d[2], 1'b1);
      enc_run = 1'b1;
      // The restart needs a round trip through both synchronisers first.
      settle(10);
      rd(ADDR_STAT);
      chk("relock", d[3:2], {(f == 1 || f == 2), 1'b0});
      settle(110);
    end
    complete_run();
  end
endmodule : aso_top_tb
